// [bench/pcat_counter_tb.sv]
// Self-checking testbench for the counter array timebase block.
`timescale 1ns/1ns

module pcat_counter_tb;
    import pcat_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic cpu_idle = 1'b0;
    pcat_axi_m2s_t m = '0;
    pcat_axi_s2m_t s;
    logic t0, pin, osc, irq;
    logic [2:0][15:0] cv;
    logic [31:0] rd_d;
    logic [1:0] rd_r;
    logic [1:0] wr_r;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;

    // ----------------------------------------------------------------
    // Clock, design and source model
    // ----------------------------------------------------------------
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    pcat_counter #(.CNT_W(16), .NUM_MODULES(3)) uut (
        .clk(clk), .clk_en(clk_en), .reset(reset),
        .axi_m(m), .axi_s(s),
        .timer0_overflow(t0), .external_count_input(pin),
        .ext_osc_div8(osc), .cpu_idle(cpu_idle),
        .counter_value(cv), .irq(irq)
    );

    pcat_source_model src (
        .clk(clk), .reset(reset), .timer0_overflow(t0),
        .external_count_input(pin), .ext_osc_div8(osc)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // Range compare; tick phase makes a window count off by one.
    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input logic [15:0] g);
        cmp_count++;
        if (^g === 1'bx || g < lo || g > hi) begin
            $display("FAIL %s expected %0d..%0d seen %h", nm, lo, hi, g);
            n_fail++;
        end
    endtask

    // ----------------------------------------------------------------
    // Bus tasks; each first lets an edge pass so no signal is set twice.
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        m.awvalid <= 1'b1;
        m.awaddr <= a;
        m.wvalid <= 1'b1;
        m.wdata <= d;
        m.wstrb <= 4'hF;
        m.bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (m.awvalid && s.awready) m.awvalid <= 1'b0;
            if (m.wvalid && s.wready) m.wvalid <= 1'b0;
            if (s.bvalid) break;
            if (++n > 100) begin
                $display("FAIL bus write expected response seen timeout");
                n_fail++;
                give_verdict();
            end
        end
        wr_r = s.bresp;
        m.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        m.arvalid <= 1'b1;
        m.araddr <= a;
        m.rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (m.arvalid && s.arready) m.arvalid <= 1'b0;
            if (s.rvalid) break;
            if (++n > 100) begin
                $display("FAIL bus read expected response seen timeout");
                n_fail++;
                give_verdict();
            end
        end
        rd_d = s.rdata;
        rd_r = s.rresp;
        m.rready <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Timebase table: mode value, processor idle, ticks in 240 cycles.
    // ----------------------------------------------------------------
    logic [7:0] md [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                            8'h06, 8'h07, 8'h0C, 8'h04};
    bit idl [10] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
    int ex [10] = '{20, 60, 30, 30, 240, 30, 0, 0, 0, 240};

    initial begin
        logic [15:0] v0;
        int t;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(OFF_MODE);
        chk("mode reset", 32'h0, rd_d);
        rd(OFF_STATUS);
        chk("status reset", 32'h0, rd_d);
        rd(OFF_CNT_HI);
        chk("snapshot reset", 32'h0, rd_d);
        rd(8'h20);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rd_r});
        $display("test reset done");
        // Stopped counter: low-byte read freezes the high byte.
        wr(OFF_MODE, 32'h6);
        wr(OFF_CNT_LO, 32'h34);
        wr(OFF_CNT_HI, 32'h12);
        chk("count value", 32'h1234, {16'h0, cv[0]});
        rd(OFF_CNT_LO);
        chk("low byte", 32'h34, rd_d);
        wr(OFF_CNT_HI, 32'h56);
        rd(OFF_CNT_HI);
        chk("snapshot high", 32'h12, rd_d);
        rd(OFF_CNT_LO);
        rd(OFF_CNT_HI);
        chk("fresh high", 32'h56, rd_d);
        $display("test snapshot done");
        // Wrap with interrupt masked, then enabled, then cleared by read.
        wr(OFF_MASK, 32'h0);
        wr(OFF_CNT_LO, 32'hFF);
        wr(OFF_CNT_HI, 32'hFF);
        wr(OFF_MODE, {24'h0, TB_SYS});
        repeat (10) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFF_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq enabled", 32'h1, {31'h0, irq});
        repeat (20) @(posedge clk);
        chk("irq held", 32'h1, {31'h0, irq});
        rd(OFF_STATUS);
        chk("overflow flag", 32'h1, rd_d);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Second wrap, cleared by writing a one; unmapped write refused.
        wr(OFF_CNT_HI, 32'hFF);
        wr(OFF_CNT_LO, 32'hF0);
        repeat (30) @(posedge clk);
        chk("irq second wrap", 32'h1, {31'h0, irq});
        wr(OFF_STATUS, 32'h1);
        chk("clear resp", {30'h0, RESP_OKAY}, {30'h0, wr_r});
        repeat (3) @(posedge clk);
        chk("irq write clear", 32'h0, {31'h0, irq});
        wr(8'h20, 32'h0);
        chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, wr_r});
        $display("test overflow done");
        // Every timebase code, idle suspend both ways, reads meanwhile.
        for (int i = 0; i < 10; i++) begin
            wr(OFF_MODE, {24'h0, md[i]});
            cpu_idle <= idl[i];
            repeat (8) @(posedge clk);
            v0 = cv[0];
            t = cyc;
            rd(OFF_CNT_LO);
            while (cyc < t + 240) @(posedge clk);
            chk_rng("ticks", (ex[i] > 0) ? ex[i] - 1 : 0, ex[i] + 1,
                    cv[0] - v0);
            chk("module copy 1", {16'h0, cv[0]}, {16'h0, cv[1]});
            chk("module copy 2", {16'h0, cv[0]}, {16'h0, cv[2]});
        end
        cpu_idle <= 1'b0;
        // Enable low freezes the counter; it resumes once enabled again.
        clk_en <= 1'b0;
        repeat (2) @(posedge clk);
        v0 = cv[0];
        repeat (20) @(posedge clk);
        chk("frozen count", {16'h0, v0}, {16'h0, cv[0]});
        clk_en <= 1'b1;
        repeat (20) @(posedge clk);
        chk_rng("resumed count", 19, 21, cv[0] - v0);
        $display("test timebase done");
        give_verdict();
    end
endmodule // pcat_counter_tb

// [bench/pcat_source_model.sv]
// Count-source model: timer 0 overflow, external count pin, oscillator/8.
`timescale 1ns/1ns

module pcat_source_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Count sources.
    output logic timer0_overflow,
    output logic external_count_input,
    output logic ext_osc_div8
);
    logic [2:0] phase_q;

    // Free-running phase; every source has an eight-cycle period.
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end

    // Falls once per eight cycles, well under a quarter of the clock.
    assign external_count_input = phase_q[2];
    assign ext_osc_div8 = phase_q[2];
    assign timer0_overflow = (phase_q == 3'h7);
endmodule // pcat_source_model

// [inc/pcat_pkg.sv]
// Shared constants and types for the counter array timebase block.
package pcat_pkg;

    // ------------------------------------------------------------------
    // Register map and bus
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int MODE_TB_LSB = 0;
    localparam int MODE_IDLE_BIT = 3;
    localparam int STAT_OVF_BIT = 0;
    localparam int MASK_OVF_BIT = 0;
    localparam logic [2:0] TB_RESET = 3'h0;

    // Timebase select codes.
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_T0 = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYS = 3'h4;
    localparam logic [2:0] TB_OSC8 = 3'h5;

    // Prescaler: counts 0..11, divide-by-4 taps every fourth state.
    localparam logic [3:0] PRESC_LAST = 4'hB;
    localparam logic [1:0] PRESC_Q4 = 2'h3;

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } pcat_axi_m2s_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcat_axi_s2m_t;

endpackage

// [src/pcat_counter.sv]
// Counter array timebase: 16-bit counter, source select, AXI4-Lite slave.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns

// Behaviour
// - counter is 16 bits, two byte registers
// - low-byte read snapshots high byte for later
// - reads never disturb counting
// - codes 000, 001, 100 pick clock divisions
// - 010 counts timer0 overflows, 011 falling edges
// - 101 counts oscillator/8, 110/111 reserved
// - oscillator tick resynchronised to system clock
// - wrap from all ones sets overflow flag
// - interrupt only while overflow enable set
// - flag stays set until software clears
// - idle_suspend low keeps counting in idle
// - counter value goes to three modules
module pcat_counter
    import pcat_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int NUM_MODULES = 3
) (
    // Clock, enable and reset.
    input wire logic clk,
    input wire logic clk_en,
    input wire logic reset,
    // Register bus.
    input pcat_axi_m2s_t axi_m,
    output pcat_axi_s2m_t axi_s,
    // Count sources and processor state.
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_div8,
    input wire logic cpu_idle,
    // Counter value to the capture/compare modules, and interrupt.
    output logic [NUM_MODULES-1:0][CNT_W-1:0] counter_value,
    output logic irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [7:0] snap;
        logic ovf_flag;
        logic [2:0] tb_sel;
        logic idle_susp;
        logic irq_en;
        logic [3:0] presc;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } pcat_state_t;

    pcat_state_t s_q;
    pcat_state_t s_d;

    logic run;
    logic presc_wrap;
    logic src_tick;
    logic tick;
    logic wr_fire;
    logic cnt_wr;
    logic rd_fire;
    logic lo_read;
    logic stat_read;
    logic ovf_set;
    logic [CNT_W-1:0] all_ones;

    // ------------------------------------------------------------------
    // Timebase selection
    // ------------------------------------------------------------------

    // Suspend only when both the processor idles and software asked for it.
    assign run = clk_en && !(s_q.idle_susp && cpu_idle);
    assign presc_wrap = (s_q.presc == PRESC_LAST);
    assign all_ones = '1;

    // Source tick picked from the select field; reserved codes never count.
    always_comb begin
        case (s_q.tb_sel)
            TB_DIV12: src_tick = presc_wrap;
            TB_DIV4: src_tick = (s_q.presc[1:0] == PRESC_Q4);
            TB_T0: src_tick = timer0_overflow;
            TB_EXT_FALL: src_tick = s_q.pin_s3 && !s_q.pin_s2;
            TB_SYS: src_tick = 1'b1;
            TB_OSC8: src_tick = s_q.osc_s2 && !s_q.osc_s3;
            default: src_tick = 1'b0;
        endcase
    end

    assign tick = run && src_tick;
    assign ovf_set = tick && (s_q.count == all_ones);

    // Bus strobes decoded from registered state and the live request.
    assign wr_fire = clk_en && s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign cnt_wr = wr_fire && s_q.wstrb[0] &&
        (s_q.aw_addr == OFF_CNT_LO || s_q.aw_addr == OFF_CNT_HI);
    assign rd_fire = clk_en && axi_m.arvalid && s_q.arready;
    assign lo_read = rd_fire && (axi_m.araddr == OFF_CNT_LO);
    assign stat_read = rd_fire && (axi_m.araddr == OFF_STATUS);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // One process computes every next value; clk_en low freezes all of it.
    always_comb begin
        s_d = s_q;
        if (clk_en) begin
            // The synchronisers run even while counting is suspended.
            s_d.pin_s1 = external_count_input;
            s_d.pin_s2 = s_q.pin_s1;
            s_d.pin_s3 = s_q.pin_s2;
            s_d.osc_s1 = ext_osc_div8;
            s_d.osc_s2 = s_q.osc_s1;
            s_d.osc_s3 = s_q.osc_s2;

            // Prescaler stops with the counter so divided ticks stay even.
            if (run) begin
                if (presc_wrap) begin
                    s_d.presc = '0;
                end else begin
                    s_d.presc = s_q.presc + 4'h1;
                end
            end

            // Counting; reads leave this path untouched.
            if (tick) begin
                s_d.count = s_q.count + 1'b1;
            end

            // Write address and data are taken independently.
            if (axi_m.awvalid && s_q.awready) begin
                s_d.aw_have = 1'b1;
                s_d.aw_addr = axi_m.awaddr;
            end
            if (axi_m.wvalid && s_q.wready) begin
                s_d.w_have = 1'b1;
                s_d.wdata = axi_m.wdata;
                s_d.wstrb = axi_m.wstrb;
            end

            // Both halves present: apply the write and raise the response.
            if (wr_fire) begin
                s_d.aw_have = 1'b0;
                s_d.w_have = 1'b0;
                s_d.bvalid = 1'b1;
                s_d.bresp = RESP_OKAY;
                case (s_q.aw_addr)
                    OFF_CNT_LO: begin
                        if (s_q.wstrb[0]) begin
                            s_d.count[7:0] = s_q.wdata[7:0];
                        end
                    end
                    OFF_CNT_HI: begin
                        if (s_q.wstrb[0]) begin
                            s_d.count[CNT_W-1:8] = s_q.wdata[7:0];
                        end
                    end
                    OFF_MODE: begin
                        if (s_q.wstrb[0]) begin
                            s_d.tb_sel =
                                s_q.wdata[MODE_TB_LSB +: 3];
                            s_d.idle_susp = s_q.wdata[MODE_IDLE_BIT];
                        end
                    end
                    OFF_STATUS: begin
                        // Writing a one clears the flag; an overflow wins.
                        if (s_q.wstrb[0] && s_q.wdata[STAT_OVF_BIT]) begin
                            s_d.ovf_flag = 1'b0;
                        end
                    end
                    OFF_MASK: begin
                        if (s_q.wstrb[0]) begin
                            s_d.irq_en = s_q.wdata[MASK_OVF_BIT];
                        end
                    end
                    default: s_d.bresp = RESP_SLVERR;
                endcase
            end
            if (s_q.bvalid && axi_m.bready) begin
                s_d.bvalid = 1'b0;
            end

            // Reads answer one cycle after the address is taken.
            if (s_q.rvalid && axi_m.rready) begin
                s_d.rvalid = 1'b0;
            end
            if (rd_fire) begin
                s_d.rvalid = 1'b1;
                s_d.rresp = RESP_OKAY;
                s_d.rdata = '0;
                case (axi_m.araddr)
                    OFF_CNT_LO: begin
                        s_d.rdata[7:0] = s_q.count[7:0];
                        s_d.snap = s_q.count[CNT_W-1:8];
                    end
                    OFF_CNT_HI: s_d.rdata[7:0] = s_q.snap;
                    OFF_MODE: begin
                        s_d.rdata[MODE_TB_LSB +: 3] = s_q.tb_sel;
                        s_d.rdata[MODE_IDLE_BIT] = s_q.idle_susp;
                    end
                    OFF_STATUS: begin
                        s_d.rdata[STAT_OVF_BIT] = s_q.ovf_flag;
                        s_d.ovf_flag = 1'b0;
                    end
                    OFF_MASK: s_d.rdata[MASK_OVF_BIT] = s_q.irq_en;
                    default: s_d.rresp = RESP_SLVERR;
                endcase
            end

            // Overflow set comes last so it beats any clear this cycle.
            if (ovf_set) begin
                s_d.ovf_flag = 1'b1;
            end

            // Ready flags are registered so every bus output is a flop.
            s_d.awready = !s_d.aw_have && !s_d.bvalid;
            s_d.wready = !s_d.w_have && !s_d.bvalid;
            s_d.arready = !s_d.rvalid;
            s_d.irq = s_d.ovf_flag && s_d.irq_en;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Synchronous reset clears everything, bus ready flags come up high.
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.tb_sel <= TB_RESET;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Every capture/compare module sees the same running count.
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
        assign counter_value[m] = s_q.count;
    end

    assign irq = s_q.irq;
    assign axi_s.awready = s_q.awready;
    assign axi_s.wready = s_q.wready;
    assign axi_s.bvalid = s_q.bvalid;
    assign axi_s.bresp = s_q.bresp;
    assign axi_s.arready = s_q.arready;
    assign axi_s.rvalid = s_q.rvalid;
    assign axi_s.rdata = s_q.rdata;
    assign axi_s.rresp = s_q.rresp;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_low_read;
        lo_read && !cnt_wr;
    endsequence

    sequence s_high_read;
        rd_fire && (axi_m.araddr == OFF_CNT_HI);
    endsequence

    sequence s_plain_tick;
        tick && !cnt_wr;
    endsequence

    // Reset leaves the counter, snapshot, flag and select at zero.
    a_reset_clear: assert property (
        $past(reset) |-> (s_q.count == '0 && s_q.snap == 8'h00 &&
            !s_q.ovf_flag && s_q.tb_sel == TB_RESET))
        else $error("reset did not clear counter state");

    // The snapshot holds the high byte seen at the low-byte read.
    a_snap_capture: assert property (
        s_low_read |=> s_q.snap == $past(s_q.count[CNT_W-1:8]))
        else $error("snapshot not taken on low byte read");

    // A high-byte read returns the snapshot, not the live byte.
    a_snap_return: assert property (
        s_high_read |=> s_q.rvalid && s_q.rdata[7:0] == $past(s_q.snap))
        else $error("high byte read did not return snapshot");

    // Each tick advances the count by exactly one.
    a_count_step: assert property (
        s_plain_tick |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("counter did not step by one");

    // A low-byte read with no tick leaves the counter alone.
    a_read_nodisturb: assert property (
        lo_read && !tick && !cnt_wr |=> $stable(s_q.count))
        else $error("read disturbed the counter");

    // Suspended in idle, the counter holds over several cycles.
    a_idle_hold: assert property (
        (clk_en && s_q.idle_susp && cpu_idle && !cnt_wr)
            |=> $stable(s_q.count))
        else $error("counter moved while suspended");

    // With suspend clear, idle does not stop the system clock source.
    a_idle_run: assert property (
        (clk_en && cpu_idle && !s_q.idle_susp &&
            s_q.tb_sel == TB_SYS && !cnt_wr)
            |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("counter stopped in idle without suspend");

    // Wrap from all ones sets the flag and zeroes the count.
    a_ovf_set: assert property (
        (tick && s_q.count == all_ones && !cnt_wr)
            |=> s_q.ovf_flag && s_q.count == '0)
        else $error("overflow did not set the flag");

    // Interrupt follows flag and enable, never the flag alone.
    a_irq_gate: assert property (
        (clk_en && s_d.ovf_flag && !s_d.irq_en) |=> !irq)
        else $error("interrupt raised while disabled");

    // Without a clear the flag stays set for the next cycles.
    a_flag_keep: assert property (
        (s_q.ovf_flag && !rd_fire && !wr_fire && !axi_m.arvalid)
            |=> s_q.ovf_flag)
        else $error("overflow flag cleared by itself");

    // The prescaler restarts after state eleven.
    a_div12_wrap: assert property (
        (run && presc_wrap) |=> s_q.presc == 4'h0)
        else $error("prescaler did not wrap");

    // A settled falling edge of the count input advances the counter.
    a_pin_fall: assert property (
        (run && s_q.tb_sel == TB_EXT_FALL && s_q.pin_s3 &&
            !s_q.pin_s2 && !cnt_wr)
            |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("count input edge missed");

    // An oscillator edge reaches the counter only through the sync chain.
    a_osc_sync: assert property (
        (run && s_q.tb_sel == TB_OSC8 && !cnt_wr &&
            !(s_q.osc_s2 && !s_q.osc_s3)) |=> $stable(s_q.count))
        else $error("oscillator tick bypassed synchroniser");

endmodule // pcat_counter
